//--- inc/dts_defs.svh
`ifndef DTS_DEFS_SVH
`define DTS_DEFS_SVH

// trace status codes
`define DTS_CODE_STALL        3'h7
`define DTS_CODE_JUMP_PC      3'h6
`define DTS_CODE_JUMP_NO_PC   3'h5
`define DTS_CODE_EXCEPTION    3'h4
`define DTS_CODE_SEQUENTIAL   3'h3
`define DTS_CODE_STALL_TRACE  3'h2
`define DTS_CODE_TRIGGER      3'h1
`define DTS_CODE_DEBUG_RUN    3'h0

// strap bit positions
`define DTS_STRAP_SRC_BIT     6
`define DTS_STRAP_ADS_BIT     5
`define DTS_STRAP_ACK_BIT     4
`define DTS_STRAP_ID_BIT      3
`define DTS_STRAP_PCST_MSB    2
`define DTS_STRAP_WIDTH       7

// debug control register field
`define DTS_PROBE_BREAK_BIT   12
`define DTS_DCR_WIDTH         32
`define DTS_DCR_RESET         32'h0000_0000

// block address field on the memory data bus
`define DTS_BLK_ADDR_MSB      31
`define DTS_BLK_ADDR_LSB      4

`endif

//--- inc/dts_pkg.sv
package dts_pkg;

  // pipeline event reported this cycle
  typedef enum logic [7:0] {
    DTS_EV_SEQ      = 8'h01,
    DTS_EV_STALL    = 8'h02,
    DTS_EV_JUMP_PC  = 8'h04,
    DTS_EV_JUMP_NPC = 8'h08,
    DTS_EV_EXC      = 8'h10,
    DTS_EV_STL_TRC  = 8'h20,
    DTS_EV_TRIG     = 8'h40,
    DTS_EV_DEBUG    = 8'h80
  } dts_event_e;

  // one local memory transaction as seen by the qualifier logic
  typedef struct packed {
    logic        start;     // transaction begins this cycle
    logic        ack;       // data acknowledge this cycle
    logic        from_dma;  // dma originated
    logic        is_data;   // data (not instruction fetch)
    logic [27:0] blk_addr;  // block address
  } dts_txn_s;

  // qualifier pin levels, active low as on the pins
  typedef struct packed {
    logic src_n;
    logic ads_n;
    logic ack_n;
    logic id_n;
  } dts_qual_s;

  typedef enum logic [2:0] {
    DTS_ST_RESET = 3'b001,
    DTS_ST_BOOT  = 3'b010,
    DTS_ST_RUN   = 3'b100
  } dts_state_e;

endpackage

//--- rtl/dts_pcst_enc.sv
`timescale 1ns/1ps
`include "dts_defs.svh"

module dts_pcst_enc
  import dts_pkg::*;
(
  input  wire logic       clk_in,    // processor clock
  input  wire logic       arst_n_in, // async reset
  input  wire dts_event_e event_in,  // pipeline event
  output logic [2:0]      code_out   // registered code
);

  logic [2:0] code_nxt;

  // event to code mapping
  always_comb begin
    unique case (event_in)
      DTS_EV_STALL:    code_nxt = `DTS_CODE_STALL;
      DTS_EV_JUMP_PC:  code_nxt = `DTS_CODE_JUMP_PC;
      DTS_EV_JUMP_NPC: code_nxt = `DTS_CODE_JUMP_NO_PC;
      DTS_EV_EXC:      code_nxt = `DTS_CODE_EXCEPTION;
      DTS_EV_SEQ:      code_nxt = `DTS_CODE_SEQUENTIAL;
      DTS_EV_STL_TRC:  code_nxt = `DTS_CODE_STALL_TRACE;
      DTS_EV_TRIG:     code_nxt = `DTS_CODE_TRIGGER;
      DTS_EV_DEBUG:    code_nxt = `DTS_CODE_DEBUG_RUN;
      default:         code_nxt = `DTS_CODE_STALL;
    endcase
  end

  // code register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_out <= `DTS_CODE_DEBUG_RUN;
    end else begin
      code_out <= code_nxt;
    end
  end

endmodule

//--- rtl/dts_trace_status.sv
`timescale 1ns/1ps
`include "dts_defs.svh"
// Notes on behaviour
// - codes 111 stall, 110 jump with pc, 101 jump without, 100 exception
// - codes 011 sequential, 010 stall trace, 001 trigger, 000 debug run
// - boot input high in the boot cycle after reset release gives debug exception, not reset exception
// - boot input is level sensitive for the exception choice; only the probe break flag latches it
// - boot input also sets probe break flag, debug control bit 12
// - debug mode select sampled on every rising test clock edge
// - source pin high for cpu, low for dma, while strobe or ack
// - active-low ack pin marks data acknowledge to cpu or dma
// - active-low strobe at transaction start with block address on data bus
// - id qualifier asserted for data, deasserted for instruction fetch
// - qualifier and trace pins double as reset-time strap bits 6 to 0

module dts_trace_status
  import dts_pkg::*;
(
  input  wire logic        CORE_CLK_IN,        // processor clock, 20 MHz
  input  wire logic        ARST_N_IN,          // async reset, active low
  input  wire dts_event_e  EVENT_IN,           // pipeline event this cycle
  input  wire dts_txn_s    TXN_IN,             // local memory transaction
  input  wire logic        DEBUG_BOOT_IN,      // debug boot level
  input  wire logic        TEST_CLK_IN,        // test clock, sampled
  input  wire logic        MODE_SEL_IN,        // debug mode select
  input  wire logic        PROBE_BREAK_CLR_IN, // clear probe break flag
  input  wire logic [2:0]  PCST_PIN_IN,        // trace pins, read back
  input  wire dts_qual_s   QUAL_PIN_IN,        // qualifier pins, read back
  output logic [2:0]       PCST_OUT,           // trace status code
  output logic [2:0]       PCST_OE_OUT,        // trace status enables
  output dts_qual_s        QUAL_OUT,           // qualifier pin levels
  output logic [3:0]       QUAL_OE_OUT,        // qualifier enables
  output logic [27:0]      BLK_ADDR_OUT,       // block address on mem data
  output logic [6:0]       STRAP_OUT,          // captured strap bits
  output logic             TAKE_DEBUG_EXC_OUT, // pulse: debug exception
  output logic             TAKE_RESET_EXC_OUT, // pulse: reset exception
  output logic             PROBE_BREAK_OUT,    // probe break flag
  output logic [31:0]      DEBUG_CTRL_OUT,     // debug control view
  output logic             MODE_SEL_OUT        // sampled mode select
);

  dts_state_e  state_r;
  dts_state_e  state_nxt;
  logic [2:0]  code_w;
  dts_qual_s   qual_r;
  dts_qual_s   qual_nxt;
  logic [27:0] blk_r;
  logic [6:0]  strap_r;
  logic        brk_r;
  logic        brk_nxt;
  logic        tck_d_r;
  logic        msel_r;
  logic        drive_w;
  logic        boot_end_w;
  logic        txn_active_w;

  // trace code encoder
  dts_pcst_enc u_enc (
    .clk_in    (CORE_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .event_in  (EVENT_IN),
    .code_out  (code_w)
  );

  // reset sequence: strap capture cycle, boot cycle, then run
  always_comb begin
    unique case (state_r)
      DTS_ST_RESET: state_nxt = DTS_ST_BOOT;
      DTS_ST_BOOT:  state_nxt = DTS_ST_RUN;
      DTS_ST_RUN:   state_nxt = DTS_ST_RUN;
      default:      state_nxt = DTS_ST_RESET;
    endcase
  end

  // sequence state register
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_r <= DTS_ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pins float until the strap cycle and the boot cycle have passed
  assign drive_w    = (state_r == DTS_ST_RUN);
  assign boot_end_w = (state_r == DTS_ST_BOOT);

  assign PCST_OE_OUT = {3{drive_w}};
  assign QUAL_OE_OUT = {4{drive_w}};
  assign PCST_OUT    = code_w;
  assign QUAL_OUT    = qual_r;

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      strap_r <= 7'h00;
    end else if (state_r == DTS_ST_RESET) begin
      strap_r <= {QUAL_PIN_IN.src_n, QUAL_PIN_IN.ads_n, QUAL_PIN_IN.ack_n,
                  QUAL_PIN_IN.id_n, PCST_PIN_IN};
    end
  end
  assign STRAP_OUT = strap_r;

  // debug or reset exception at sequence end
  // boot level used directly, no latch
  assign TAKE_DEBUG_EXC_OUT = boot_end_w & DEBUG_BOOT_IN;
  assign TAKE_RESET_EXC_OUT = boot_end_w & ~DEBUG_BOOT_IN;

  // boot sets probe break, set wins over clear
  assign brk_nxt = DEBUG_BOOT_IN | (brk_r & ~PROBE_BREAK_CLR_IN);

  // probe break flag register
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      brk_r <= 1'b0;
    end else begin
      brk_r <= brk_nxt;
    end
  end
  assign PROBE_BREAK_OUT = brk_r;

  // debug control view with the break flag at its bit
  always_comb begin
    DEBUG_CTRL_OUT = `DTS_DCR_RESET;
    DEBUG_CTRL_OUT[`DTS_PROBE_BREAK_BIT] = brk_r;
  end

  // sample mode select on test clock rise
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tck_d_r <= 1'b0;
      msel_r  <= 1'b0;
    end else begin
      tck_d_r <= TEST_CLK_IN;
      if (TEST_CLK_IN && !tck_d_r) begin
        msel_r <= MODE_SEL_IN;
      end
    end
  end
  assign MODE_SEL_OUT = msel_r;

  // a transaction shows while strobe or ack
  assign txn_active_w = TXN_IN.start | TXN_IN.ack;

  // qualifier next values
  always_comb begin
    qual_nxt = '{src_n: 1'b1, ads_n: 1'b1, ack_n: 1'b1, id_n: 1'b1};
    qual_nxt.ads_n = ~TXN_IN.start;
    qual_nxt.ack_n = ~TXN_IN.ack;
    if (txn_active_w) begin
      // high for cpu, low for dma
      qual_nxt.src_n = ~TXN_IN.from_dma;
      // low for data, high for fetch
      qual_nxt.id_n  = ~TXN_IN.is_data;
    end
  end

  // qualifier and block address registers
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      qual_r <= '{src_n: 1'b1, ads_n: 1'b1, ack_n: 1'b1, id_n: 1'b1};
      blk_r  <= 28'h0000000;
    end else begin
      qual_r <= qual_nxt;
      if (TXN_IN.start) begin
        blk_r <= TXN_IN.blk_addr;
      end
    end
  end
  assign BLK_ADDR_OUT = blk_r;

  // assertions
  a_float_in_reset: assert property (@(posedge CORE_CLK_IN)
    !ARST_N_IN |-> PCST_OE_OUT == 3'h0 && QUAL_OE_OUT == 4'h0)
    else $error("pins driven during reset");

  a_strobe_start: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    TXN_IN.start |=> !QUAL_OUT.ads_n && BLK_ADDR_OUT == $past(TXN_IN.blk_addr))
    else $error("strobe or block address missing");

  a_ack_pin: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    TXN_IN.ack |=> !QUAL_OUT.ack_n)
    else $error("ack not asserted");

  a_source_qual: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    txn_active_w |=> QUAL_OUT.src_n == !$past(TXN_IN.from_dma))
    else $error("source qualifier wrong");

  a_data_qual: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    txn_active_w |=> QUAL_OUT.id_n == !$past(TXN_IN.is_data))
    else $error("instruction data qualifier wrong");

  a_stall_code: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    EVENT_IN == DTS_EV_STALL |=> PCST_OUT == 3'h7)
    else $error("stall code wrong");

  a_seq_code: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    EVENT_IN == DTS_EV_SEQ |=> PCST_OUT == 3'h3)
    else $error("sequential code wrong");

  a_boot_debug: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    $rose(ARST_N_IN) && DEBUG_BOOT_IN ##1 DEBUG_BOOT_IN |-> TAKE_DEBUG_EXC_OUT)
    else $error("debug exception not taken");

  a_boot_level: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    boot_end_w |-> TAKE_DEBUG_EXC_OUT == DEBUG_BOOT_IN && TAKE_RESET_EXC_OUT != DEBUG_BOOT_IN)
    else $error("boot level not followed");

  a_break_set: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    DEBUG_BOOT_IN |=> PROBE_BREAK_OUT && DEBUG_CTRL_OUT[12])
    else $error("probe break not set");

  a_mode_sample: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    TEST_CLK_IN && !tck_d_r |=> MODE_SEL_OUT == $past(MODE_SEL_IN))
    else $error("mode select not sampled");

  a_strap_capture: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    state_r == DTS_ST_RESET |=> STRAP_OUT[6] == $past(QUAL_PIN_IN.src_n)
      && STRAP_OUT[2:0] == $past(PCST_PIN_IN))
    else $error("strap not captured");

  a_jump_pc_code: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    EVENT_IN == DTS_EV_JUMP_PC |=> PCST_OUT == 3'h6)
    else $error("jump with pc code wrong");

  a_jump_npc_code: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    EVENT_IN == DTS_EV_JUMP_NPC |=> PCST_OUT == 3'h5)
    else $error("jump without pc code wrong");

  a_exc_code: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    EVENT_IN == DTS_EV_EXC |=> PCST_OUT == 3'h4)
    else $error("exception code wrong");

  a_illegal_event: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    $countones(EVENT_IN) != 1 |=> PCST_OUT == 3'h7)
    else $error("illegal event not shown as stall");

  a_stl_trc_code: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    EVENT_IN == DTS_EV_STL_TRC |=> PCST_OUT == 3'h2)
    else $error("stall trace code wrong");

  a_trig_code: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    EVENT_IN == DTS_EV_TRIG |=> PCST_OUT == 3'h1)
    else $error("trigger code wrong");

  a_debug_code: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    EVENT_IN == DTS_EV_DEBUG |=> PCST_OUT == 3'h0)
    else $error("debug run code wrong");

  a_boot_reset: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    $rose(ARST_N_IN) && !DEBUG_BOOT_IN ##1 !DEBUG_BOOT_IN
      |-> TAKE_RESET_EXC_OUT && !TAKE_DEBUG_EXC_OUT)
    else $error("reset exception not taken");

  a_exc_once: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    TAKE_DEBUG_EXC_OUT || TAKE_RESET_EXC_OUT |=> !TAKE_DEBUG_EXC_OUT && !TAKE_RESET_EXC_OUT)
    else $error("exception pulse too long");

  a_break_hold: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    PROBE_BREAK_OUT && !PROBE_BREAK_CLR_IN |=> PROBE_BREAK_OUT)
    else $error("probe break lost");

  a_break_clear: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    !DEBUG_BOOT_IN && PROBE_BREAK_CLR_IN |=> !PROBE_BREAK_OUT)
    else $error("probe break not cleared");

  a_dcr_fields: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    DEBUG_CTRL_OUT == {19'h0, PROBE_BREAK_OUT, 12'h000})
    else $error("debug control view wrong");

  a_mode_hold: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    !(TEST_CLK_IN && !tck_d_r) |=> $stable(MODE_SEL_OUT))
    else $error("mode select changed without test clock rise");

  a_ack_idle: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    !TXN_IN.ack |=> QUAL_OUT.ack_n)
    else $error("ack asserted without acknowledge");

  a_strobe_idle: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    !TXN_IN.start |=> QUAL_OUT.ads_n && $stable(BLK_ADDR_OUT))
    else $error("strobe or block address without start");

  a_idle_quals: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    !txn_active_w |=> QUAL_OUT.src_n && QUAL_OUT.id_n)
    else $error("qualifiers not idle outside transactions");

  a_drive_after: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    $rose(ARST_N_IN) |-> PCST_OE_OUT == 3'h0 && QUAL_OE_OUT == 4'h0
      ##1 PCST_OE_OUT == 3'h0 && QUAL_OE_OUT == 4'h0
      ##1 PCST_OE_OUT == 3'h7 && QUAL_OE_OUT == 4'hf)
    else $error("pins not driven after strap cycle");

  a_strap_mid: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    state_r == DTS_ST_RESET |=> STRAP_OUT[5] == $past(QUAL_PIN_IN.ads_n)
      && STRAP_OUT[4] == $past(QUAL_PIN_IN.ack_n) && STRAP_OUT[3] == $past(QUAL_PIN_IN.id_n))
    else $error("strap middle bits not captured");

  a_strap_hold: assert property (@(posedge CORE_CLK_IN) disable iff (!ARST_N_IN)
    state_r != DTS_ST_RESET |=> $stable(STRAP_OUT))
    else $error("strap changed after capture");

endmodule

//--- sim/dts_probe_model.sv
`timescale 1ns/1ps
// probe side of the trace and qualifier pins, with strap pulls
module dts_probe_model
  import dts_pkg::*;
(
  input  wire logic [2:0] pcst_in,      // device trace code
  input  wire logic [2:0] pcst_oe_in,   // device trace enables
  input  wire dts_qual_s  qual_in,      // device qualifier levels
  input  wire logic [3:0] qual_oe_in,   // device qualifier enables
  input  wire logic [6:0] strap_in,     // strap pull levels
  output logic [2:0]      pcst_pin_out, // resolved trace pins
  output dts_qual_s       qual_pin_out  // resolved qualifier pins
);
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pcst_pin_out[i] = pcst_oe_in[i] ? pcst_in[i] : strap_in[i];
    end
    for (int i = 0; i < 4; i++) begin
      qual_pin_out[i] = qual_oe_in[i] ? qual_in[i] : strap_in[i+3];
    end
  end
endmodule

//--- sim/dts_trace_status_test.sv
`timescale 1ns/1ps
module dts_trace_status_test;
  import dts_pkg::*;
  logic        clk, arst_n, boot, tclk, msel, bclr, dbg_exc, rst_exc, flag, msel_q;
  dts_event_e  ev;
  dts_txn_s    txn;
  dts_qual_s   qual, qual_pin;
  logic [6:0]  strap, strap_q;
  logic [2:0]  pcst, pcst_oe, pcst_pin;
  logic [3:0]  qual_oe;
  logic [27:0] blk, blk_exp;
  logic [31:0] dcr;
  int          num_errors = 0, comparisons = 0, cycles = 0;

  dts_trace_status dut (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .EVENT_IN(ev), .TXN_IN(txn),
    .DEBUG_BOOT_IN(boot), .TEST_CLK_IN(tclk), .MODE_SEL_IN(msel), .PROBE_BREAK_CLR_IN(bclr),
    .PCST_PIN_IN(pcst_pin), .QUAL_PIN_IN(qual_pin), .PCST_OUT(pcst), .PCST_OE_OUT(pcst_oe),
    .QUAL_OUT(qual), .QUAL_OE_OUT(qual_oe), .BLK_ADDR_OUT(blk), .STRAP_OUT(strap_q),
    .TAKE_DEBUG_EXC_OUT(dbg_exc), .TAKE_RESET_EXC_OUT(rst_exc), .PROBE_BREAK_OUT(flag),
    .DEBUG_CTRL_OUT(dcr), .MODE_SEL_OUT(msel_q));
  dts_probe_model probe (.pcst_in(pcst), .pcst_oe_in(pcst_oe), .qual_in(qual),
    .qual_oe_in(qual_oe), .strap_in(strap), .pcst_pin_out(pcst_pin), .qual_pin_out(qual_pin));

  // clock and hang guard
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // reference code per event, non-one-hot reads as stall
  function automatic logic [2:0] code_of(input logic [7:0] e);
    case (e)
      8'h01: code_of = 3'h3;
      8'h04: code_of = 3'h6;
      8'h08: code_of = 3'h5;
      8'h10: code_of = 3'h4;
      8'h20: code_of = 3'h2;
      8'h40: code_of = 3'h1;
      8'h80: code_of = 3'h0;
      default: code_of = 3'h7;
    endcase
  endfunction

  task automatic do_reset(input logic b);
    @(posedge clk);
    arst_n <= 1'b0;
    boot   <= !b;
    tclk   <= 1'b0;
    strap  <= 7'($urandom);
    repeat (4) @(posedge clk);
    // only the level near release counts
    boot   <= b;
    repeat (3) @(posedge clk);
    #1 chk({pcst_oe, qual_oe}, 0);
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1 chk(strap_q, strap);
    chk({dbg_exc, rst_exc}, {b, !b});
    chk(dcr, {19'h0, b, 12'h0});
    @(posedge clk);
    #1 chk({pcst_oe, qual_oe, dbg_exc, rst_exc}, 9'h1fc);
    $display("test reset done");
  endtask

  task automatic run_traffic(input int n);
    logic [7:0] e, pe;
    dts_txn_s   t, pt;
    logic       a;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      e = (i == 8) ? 8'h03 : 8'h01 << ((i < 8) ? i : $urandom_range(7));
      t = dts_txn_s'($urandom);
      ev  <= dts_event_e'(e);
      txn <= t;
      #1;
      if (i > 0) begin
        a = pt.start | pt.ack;
        if (pt.start) blk_exp = pt.blk_addr;
        chk(pcst, code_of(pe));
        chk(qual.src_n, !(a & pt.from_dma));
        chk(qual.ack_n, !pt.ack);
        chk({qual.ads_n, blk}, {!pt.start, blk_exp});
        chk(qual.id_n, !(a & pt.is_data));
      end
      pe = e;
      pt = t;
    end
    $display("test traffic done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h3642));
    arst_n = 0; boot = 0; tclk = 0; msel = 0; bclr = 0;
    ev = DTS_EV_SEQ; txn = '0; strap = '0; blk_exp = '0;
    do_reset(1'b1);
    @(posedge clk);
    boot <= 1'b0;
    bclr <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(flag, 1'b0);
    @(posedge clk);
    boot <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(dcr[12], 1'b1);
    @(posedge clk);
    bclr <= 1'b0;
    boot <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(dcr, 32'h0000_1000);
    $display("test boot flag done");
    run_traffic(40);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      tclk <= 1'b0;
      msel <= k[0];
      @(posedge clk);
      tclk <= 1'b1;
      @(posedge clk);
      msel <= !k[0];
      repeat (2) @(posedge clk);
      #1 chk(msel_q, k[0]);
    end
    $display("test mode select done");
    do_reset(1'b0);
    run_traffic(20);
    report_and_stop();
  end
endmodule
